// >>> hdl/crm_pkg.sv
// shared constants for the CAN reset, configuration and pin monitor block
package crm_pkg;
	// ------------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [11:0] MBOX_DATA_BASE   = 12'h000;
	localparam logic [11:0] PIN_MONITOR_OFF  = 12'h200;
	localparam logic [11:0] MASTER_CTRL_OFF  = 12'h204;
	localparam logic [11:0] GLOBAL_STAT_OFF  = 12'h208;
	localparam logic [11:0] IRQ_FLAGS_OFF    = 12'h20c;
	localparam logic [11:0] BIT_CONFIG_OFF   = 12'h210;
	localparam logic [11:0] ERR_COUNT_OFF    = 12'h214;
	localparam int          MBOX_COUNT       = 16;
	localparam int          MBOX_BYTES       = 8;
	localparam int          MBOX_CELLS       = MBOX_COUNT * MBOX_BYTES;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int RX_IRQ_SEL_BIT   = 7;
	localparam int TX_HOLD_BIT      = 6;
	localparam int TX_LEVEL_BIT     = 1;
	localparam int RX_LEVEL_BIT     = 0;
	localparam int RESET_REQ_BIT    = 0;
	localparam int TX_METHOD_BIT    = 2;
	localparam int RESET_STATE_BIT  = 3;
	localparam int BUS_ON_BIT       = 4;
	localparam int RESET_IRQ_BIT    = 0;
	localparam int BRP_LSB          = 0;
	localparam int SJW_LSB          = 6;
	localparam int TIME_SEGMENT_ONE_LSB        = 8;
	localparam int TIME_SEGMENT_TWO_LSB        = 12;
	localparam int BSP_BIT          = 15;

	// ------------------------------------------------------------------
	// reset values and timing counts
	// ------------------------------------------------------------------
	localparam logic [15:0] BIT_CONFIG_RESET = 16'h0000;
	localparam logic [7:0]  ERR_MAX          = 8'hff;
	localparam logic [4:0]  INTERNAL_RESET_CYCLES = 5'h10;
	localparam logic [3:0]  RECESSIVE_RUN    = 4'hb;

	typedef enum logic [2:0] {
		ST_CONFIG  = 3'b000,
		ST_LEAVING = 3'b001,
		ST_POWERUP = 3'b010,
		ST_ACTIVE  = 3'b011,
		ST_DRAIN   = 3'b100
	} crm_state_e;
endpackage : crm_pkg

// >>> hdl/crm_can_ctrl.sv
// CAN controller reset, configuration, bit timing, mailbox data and pins
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns

// What this block does
// - sixteen mailboxes, each holding eight byte-wide data registers
// - receive interrupt select resets to 0; 0 port pin, 1 CAN receive pin
// - transmit stop resets to 0; when 1 transmit pin held at 1
// - monitor bits 5 to 2 ignore writes and read 0
// - monitor bit 1 shows transmit pin, bit 0 receive pin, read only
// - hardware reset or standby sets request and state bits, keeps RAM
// - software reset request clears only both error counters
// - software reset during a transfer waits until the transfer ends
// - reset state bit is set once initialisation has finished
// - clearing request leaves configuration; state bit clears after internal delay
// - power-up waits for eleven consecutive recessive bits before communicating
// - reset interrupt flag set after power-on or standby; software clears it
// - bit rate and timing come from the bit configuration register
// - bit has sync, propagation and two phase buffer segments
// - resync lengthens phase buffer one or shortens phase buffer two
// - quantum is 2*(prescaler+1) clocks; bit is quantum*(3+seg1+seg2)
module crm_can_ctrl (
	input  wire logic        MCLK,
	input  wire logic        RESETN,
	input  wire logic        STANDBY,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        CAN_RECEIVE_PIN,
	input  wire logic        GENERAL_PORT_PIN,
	input  wire logic        TX_ENGINE_BIT,
	input  wire logic        MSG_BUSY,
	input  wire logic        TX_ERR_INC,
	input  wire logic        RX_ERR_INC,
	output logic             CAN_TRANSMIT_PIN,
	output logic             SECOND_EXTERNAL_IRQ,
	output logic             BUS_ON,
	output logic             SAMPLE_TICK,
	output logic             SAMPLED_BIT
);
	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [1:0] pin_async;
	logic [1:0] pin_meta_reg;
	logic [1:0] pin_sync_reg;
	assign pin_async = {GENERAL_PORT_PIN, CAN_RECEIVE_PIN};

	for (genvar g = 0; g < 2; g++) begin : g_sync
		always_ff @(posedge MCLK or negedge RESETN) begin
			if (!RESETN) begin
				pin_meta_reg[g] <= 1'b1;
				pin_sync_reg[g] <= 1'b1;
			end else begin
				pin_meta_reg[g] <= pin_async[g];
				pin_sync_reg[g] <= pin_meta_reg[g];
			end
		end
	end
	wire rx_level   = pin_sync_reg[0];
	wire port_level = pin_sync_reg[1];

	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a[11:2] == o[11:2]);
	endfunction : hit

	wire        access   = PSEL && PENABLE && PREADY;
	wire        wr       = access && PWRITE;
	wire        in_ram   = (PADDR[11:9] == crm_pkg::MBOX_DATA_BASE[11:9]);
	wire [6:0]  ram_idx  = PADDR[8:2];
	wire        hit_mon  = hit(PADDR, crm_pkg::PIN_MONITOR_OFF);
	wire        hit_mcr  = hit(PADDR, crm_pkg::MASTER_CTRL_OFF);
	wire        hit_gsr  = hit(PADDR, crm_pkg::GLOBAL_STAT_OFF);
	wire        hit_irq  = hit(PADDR, crm_pkg::IRQ_FLAGS_OFF);
	wire        hit_bcr  = hit(PADDR, crm_pkg::BIT_CONFIG_OFF);
	wire        hit_err  = hit(PADDR, crm_pkg::ERR_COUNT_OFF);
	wire        mapped   = in_ram || hit_mon || hit_mcr || hit_gsr
	                       || hit_irq || hit_bcr || hit_err;

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	logic [7:0]  mbox_ram [crm_pkg::MBOX_CELLS];
	logic        rx_sel_reg;
	logic        tx_hold_reg;
	logic        reset_req_reg;
	logic        tx_method_reg;
	logic        reset_irq_reg;
	logic [15:0] bcr_reg;
	logic [7:0]  tec_reg;
	logic [7:0]  rec_reg;
	logic        standby_reg;
	crm_pkg::crm_state_e state_reg;
	crm_pkg::crm_state_e state_next;

	wire standby_exit = standby_reg && !STANDBY;
	wire sw_reset_done = (state_reg == crm_pkg::ST_DRAIN) && !MSG_BUSY;

	// plain storage with no reset, so it survives every reset kind
	always_ff @(posedge MCLK) begin
		if (wr && in_ram) begin
			mbox_ram[ram_idx] <= PWDATA[7:0];
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			rx_sel_reg    <= 1'b0;
			tx_hold_reg   <= 1'b0;
			reset_req_reg <= 1'b1;
			tx_method_reg <= 1'b0;
			bcr_reg       <= crm_pkg::BIT_CONFIG_RESET;
			standby_reg   <= 1'b0;
		end else if (STANDBY) begin
			rx_sel_reg    <= 1'b0;
			tx_hold_reg   <= 1'b0;
			reset_req_reg <= 1'b1;
			tx_method_reg <= 1'b0;
			bcr_reg       <= crm_pkg::BIT_CONFIG_RESET;
			standby_reg   <= 1'b1;
		end else begin
			standby_reg <= 1'b0;
			if (wr && hit_mon) begin
				// bits 5 to 2 and 1 to 0 have no storage
				rx_sel_reg  <= PWDATA[crm_pkg::RX_IRQ_SEL_BIT];
				tx_hold_reg <= PWDATA[crm_pkg::TX_HOLD_BIT];
			end
			if (wr && hit_mcr) begin
				reset_req_reg <= PWDATA[crm_pkg::RESET_REQ_BIT];
				tx_method_reg <= PWDATA[crm_pkg::TX_METHOD_BIT];
			end
			if (wr && hit_bcr) begin
				bcr_reg <= PWDATA[15:0];
			end
		end
	end

	// set wins over a software clear in the same cycle
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			reset_irq_reg <= 1'b1;
		end else if (standby_exit) begin
			reset_irq_reg <= 1'b1;
		end else if (wr && hit_irq && PWDATA[crm_pkg::RESET_IRQ_BIT]) begin
			reset_irq_reg <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			tec_reg <= 8'h00;
			rec_reg <= 8'h00;
		end else if (STANDBY || sw_reset_done) begin
			tec_reg <= 8'h00;
			rec_reg <= 8'h00;
		end else begin
			if (TX_ERR_INC && tec_reg != crm_pkg::ERR_MAX) begin
				tec_reg <= tec_reg + 8'h01;
			end
			if (RX_ERR_INC && rec_reg != crm_pkg::ERR_MAX) begin
				rec_reg <= rec_reg + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------------
	// reset and configuration sequencing
	// ------------------------------------------------------------------
	logic [4:0] delay_reg;
	logic [3:0] recessive_reg;
	logic       sample_now;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			crm_pkg::ST_CONFIG: begin
				if (!reset_req_reg) begin
					state_next = crm_pkg::ST_LEAVING;
				end
			end
			crm_pkg::ST_LEAVING: begin
				if (reset_req_reg) begin
					state_next = crm_pkg::ST_CONFIG;
				end else if (delay_reg == crm_pkg::INTERNAL_RESET_CYCLES) begin
					state_next = crm_pkg::ST_POWERUP;
				end
			end
			crm_pkg::ST_POWERUP, crm_pkg::ST_ACTIVE: begin
				if (reset_req_reg) begin
					state_next = crm_pkg::ST_DRAIN;
				end else if (sample_now && rx_level
				             && recessive_reg == crm_pkg::RECESSIVE_RUN - 4'h1) begin
					state_next = crm_pkg::ST_ACTIVE;
				end
			end
			crm_pkg::ST_DRAIN: begin
				if (!MSG_BUSY) begin
					state_next = crm_pkg::ST_CONFIG;
				end
			end
			default: state_next = crm_pkg::ST_CONFIG;
		endcase
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= crm_pkg::ST_CONFIG;
			delay_reg <= 5'h00;
		end else if (STANDBY) begin
			state_reg <= crm_pkg::ST_CONFIG;
			delay_reg <= 5'h00;
		end else begin
			state_reg <= state_next;
			delay_reg <= (state_reg == crm_pkg::ST_LEAVING) ?
			             delay_reg + 5'h01 : 5'h00;
		end
	end

	// configuration mode shown until the internal reset delay ends
	wire reset_state = (state_reg == crm_pkg::ST_CONFIG)
	                   || (state_reg == crm_pkg::ST_LEAVING);
	wire bus_live    = (state_reg == crm_pkg::ST_POWERUP)
	                   || (state_reg == crm_pkg::ST_ACTIVE)
	                   || (state_reg == crm_pkg::ST_DRAIN);

	// ------------------------------------------------------------------
	// bit timing
	// ------------------------------------------------------------------
	wire [5:0] prescaler_setting   = bcr_reg[crm_pkg::BRP_LSB +: 6];
	wire [1:0] jump_width   = bcr_reg[crm_pkg::SJW_LSB +: 2];
	wire [3:0] time_segment_one = bcr_reg[crm_pkg::TIME_SEGMENT_ONE_LSB +: 4];
	wire [2:0] time_segment_two = bcr_reg[crm_pkg::TIME_SEGMENT_TWO_LSB +: 3];
	wire [6:0] tq_len   = {prescaler_setting + 6'h01, 1'b0};
	wire [4:0] jump     = {3'h0, jump_width} + 5'h01;
	// sync is quantum 0; prop plus phase one fill up to seg1_end
	logic [4:0] ext_reg;
	logic [4:0] short_reg;
	logic [6:0] clk_cnt_reg;
	logic [4:0] q_reg;
	logic       rx_prev_reg;
	wire [4:0] seg1_end = 5'(time_segment_one) + 5'h02 + ext_reg;
	wire [4:0] bit_len  = 5'(time_segment_one) + 5'(time_segment_two) + 5'h03
	                      + ext_reg - short_reg;
	wire       tq_tick  = (clk_cnt_reg == tq_len - 7'h01);
	wire       bit_end  = tq_tick && (q_reg >= bit_len - 5'h01);
	wire       fall     = rx_prev_reg && !rx_level;
	// resync: edge in phase one stretches it, in phase two trims it
	wire       edge_ph1 = fall && q_reg != 5'h00 && q_reg < seg1_end;
	wire       edge_ph2 = fall && q_reg >= seg1_end;
	assign sample_now = tq_tick && (q_reg == seg1_end - 5'h01);

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			clk_cnt_reg <= 7'h00;
			q_reg       <= 5'h00;
			ext_reg     <= 5'h00;
			short_reg   <= 5'h00;
			rx_prev_reg <= 1'b1;
		end else if (!bus_live) begin
			clk_cnt_reg <= 7'h00;
			q_reg       <= 5'h00;
			ext_reg     <= 5'h00;
			short_reg   <= 5'h00;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_prev_reg <= rx_level;
			clk_cnt_reg <= tq_tick ? 7'h00 : clk_cnt_reg + 7'h01;
			if (bit_end) begin
				q_reg     <= 5'h00;
				ext_reg   <= 5'h00;
				short_reg <= 5'h00;
			end else begin
				if (tq_tick) begin
					q_reg <= q_reg + 5'h01;
				end
				if (edge_ph1 && ext_reg == 5'h00) begin
					ext_reg <= jump;
				end
				if (edge_ph2 && short_reg == 5'h00) begin
					// never trim past the current quantum
					short_reg <= (bit_len - q_reg - 5'h01 < jump) ?
					             bit_len - q_reg - 5'h01 : jump;
				end
			end
		end
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			recessive_reg <= 4'h0;
		end else if (!bus_live) begin
			recessive_reg <= 4'h0;
		end else if (sample_now) begin
			if (!rx_level) begin
				recessive_reg <= 4'h0;
			end else if (recessive_reg != crm_pkg::RECESSIVE_RUN) begin
				recessive_reg <= recessive_reg + 4'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// read mux and registered outputs
	// ------------------------------------------------------------------
	wire [7:0]  mon_rd  = {rx_sel_reg, tx_hold_reg, 4'h0,
	                       CAN_TRANSMIT_PIN, rx_level};
	wire [31:0] rd_data =
		in_ram  ? {24'h0, mbox_ram[ram_idx]} :
		hit_mon ? {24'h0, mon_rd} :
		hit_mcr ? 32'(reset_req_reg)
		          | (32'(tx_method_reg) << crm_pkg::TX_METHOD_BIT) :
		hit_gsr ? (32'(reset_state) << crm_pkg::RESET_STATE_BIT)
		          | (32'(state_reg == crm_pkg::ST_ACTIVE) << crm_pkg::BUS_ON_BIT) :
		hit_irq ? 32'(reset_irq_reg) :
		hit_bcr ? {16'h0, bcr_reg} :
		hit_err ? {16'h0, rec_reg, tec_reg} : 32'h0;
	wire        tx_level = tx_hold_reg ? 1'b1 : TX_ENGINE_BIT;
	// recessive in power-up; a draining frame may still finish
	wire        tx_live  = (state_reg == crm_pkg::ST_ACTIVE)
	                       || (state_reg == crm_pkg::ST_DRAIN && MSG_BUSY);
	wire        second_external_irq_src = rx_sel_reg ? rx_level : port_level;

	// one wait state keeps read data straight from a flip-flop
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			PREADY              <= 1'b0;
			PRDATA              <= 32'h0;
			PSLVERR             <= 1'b0;
			CAN_TRANSMIT_PIN    <= 1'b1;
			SECOND_EXTERNAL_IRQ <= 1'b1;
			BUS_ON              <= 1'b0;
			SAMPLE_TICK         <= 1'b0;
			SAMPLED_BIT         <= 1'b1;
		end else begin
			PREADY              <= PSEL && PENABLE && !PREADY;
			PRDATA              <= (PSEL && PENABLE && !PREADY && !PWRITE) ?
			                       rd_data : 32'h0;
			PSLVERR             <= PSEL && PENABLE && !PREADY && !mapped;
			CAN_TRANSMIT_PIN    <= tx_live ? tx_level : 1'b1;
			SECOND_EXTERNAL_IRQ <= second_external_irq_src;
			BUS_ON              <= (state_reg == crm_pkg::ST_ACTIVE);
			SAMPLE_TICK         <= sample_now && bus_live;
			SAMPLED_BIT         <= sample_now ? rx_level : SAMPLED_BIT;
		end
	end
endmodule : crm_can_ctrl

// >>> tb/crm_bus_node.sv
// other nodes on the shared bus, wired-and with our transmit pin
`timescale 1ns/1ns
module crm_bus_node (
	input  wire logic mclk,
	input  wire logic tx_pin,
	input  wire logic force_dom,
	output logic      bus_level
);
	logic dom_reg;

	always_ff @(posedge mclk) dom_reg <= force_dom;
	// dominant wins; with nobody driving the bus rests recessive
	assign bus_level = tx_pin & ~dom_reg;
endmodule : crm_bus_node

// >>> tb/crm_can_ctrl_assertions.sv
// port-level assertions for the can control block
`timescale 1ns/1ns
module crm_can_ctrl_chk (
	input wire logic        MCLK,
	input wire logic        RESETN,
	input wire logic        STANDBY,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        MSG_BUSY,
	input wire logic        CAN_TRANSMIT_PIN,
	input wire logic        BUS_ON,
	input wire logic        SAMPLE_TICK,
	input wire logic        SAMPLED_BIT
);
	// ---------------------------------------------------------------
	// bus and pin relations
	// ---------------------------------------------------------------
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	sequence s_access; PSEL && PENABLE && !PREADY; endsequence
	sequence s_quiet; (!BUS_ON && !MSG_BUSY) [*2]; endsequence

	a_ready_next: assert property (s_access |=> PREADY)
		else $error("access phase not answered");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	a_rdata_quiet: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data outside answer");
	a_err_map: assert property (PREADY |-> PSLVERR == (PADDR > 12'h217))
		else $error("error response wrong for address");
	a_idle_recessive: assert property (s_quiet |-> CAN_TRANSMIT_PIN)
		else $error("transmit pin dominant while off bus");
	a_tick_single: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
		else $error("sample tick longer than one cycle");
	a_bit_held: assert property (!SAMPLE_TICK |-> $stable(SAMPLED_BIT))
		else $error("sampled bit moved off the sample point");
	a_standby_off: assert property (STANDBY |=> ##1 (!BUS_ON && CAN_TRANSMIT_PIN))
		else $error("standby left the bus live");
endmodule : crm_can_ctrl_chk

bind crm_can_ctrl crm_can_ctrl_chk u_chk (.MCLK(MCLK), .RESETN(RESETN),
	.STANDBY(STANDBY), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MSG_BUSY(MSG_BUSY),
	.CAN_TRANSMIT_PIN(CAN_TRANSMIT_PIN), .BUS_ON(BUS_ON),
	.SAMPLE_TICK(SAMPLE_TICK), .SAMPLED_BIT(SAMPLED_BIT));

// >>> tb/crm_can_ctrl_tb.sv
// self-checking bench for the can control block
`timescale 1ns/1ns
module crm_can_ctrl_tb;
	typedef struct {
		logic        wr;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} crm_row_s;
	logic        mclk = 0, resetn = 0, standby = 0, psel = 0, penable = 0;
	logic        pwrite = 0, port_pin = 1, eng_bit = 1, busy = 0, dom = 0;
	logic        tx_inc = 0, rx_inc = 0, se;
	logic        pready, pslverr, rx_pin, tx_pin, irq, bus_on, tick, sbit;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	int          err_total = 0, checked = 0, n;
	crm_row_s    rows [12] = '{
		'{0, 12'h200, 0, 32'h3},
		'{0, 12'h204, 0, 32'h1},
		'{0, 12'h208, 0, 32'h8},
		'{0, 12'h20c, 0, 32'h1},
		'{0, 12'h214, 0, 32'h0},
		'{1, 12'h20c, 32'h1, 0},
		'{0, 12'h20c, 0, 32'h0},
		'{1, 12'h210, 32'h2300, 0},
		'{0, 12'h210, 0, 32'h2300},
		'{1, 12'h200, 32'hff, 0},
		'{0, 12'h200, 0, 32'hc3},
		'{0, 12'h300, 0, 32'h0}
	};

	always #4 mclk = ~mclk;

	crm_can_ctrl DUT (.MCLK(mclk), .RESETN(resetn), .STANDBY(standby),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CAN_RECEIVE_PIN(rx_pin),
		.GENERAL_PORT_PIN(port_pin), .TX_ENGINE_BIT(eng_bit),
		.MSG_BUSY(busy), .TX_ERR_INC(tx_inc), .RX_ERR_INC(rx_inc),
		.CAN_TRANSMIT_PIN(tx_pin), .SECOND_EXTERNAL_IRQ(irq),
		.BUS_ON(bus_on), .SAMPLE_TICK(tick), .SAMPLED_BIT(sbit));
	crm_bus_node u_node (.mclk(mclk), .tx_pin(tx_pin), .force_dom(dom),
		.bus_level(rx_pin));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// one apb transfer; waits on ready, the watchdog bounds the wait
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic rc(input logic [11:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		check(nm, rd, e);
	endtask : rc

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (5000) @(posedge mclk);
		err_total++;
		tally_and_finish;
	end

	initial begin
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			check("row data", rd, rows[i].e);
			check("row err", se, rows[i].a > 12'h214);
		end
		$display("test register table done");
		for (int i = 0; i < crm_pkg::MBOX_CELLS; i++)
			apb(1'b1, 12'(4 * i), 32'(i[7:0] ^ 8'h5a));
		for (int i = 0; i < crm_pkg::MBOX_CELLS; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0);
			check("mailbox", rd, 32'(i[7:0] ^ 8'h5a));
		end
		$display("test mailbox data done");
		apb(1'b1, 12'h204, 32'h5);
		dom <= 1'b1;
		repeat (5) @(posedge mclk);
		check("irq from rx", irq, 1'b0);
		apb(1'b1, 12'h200, 32'h0);
		repeat (4) @(posedge mclk);
		check("irq from port", irq, 1'b1);
		rc(12'h200, 32'h2, "pin levels");
		dom <= 1'b0;
		$display("test irq select done");
		apb(1'b1, 12'h204, 32'h4);
		rc(12'h208, 32'h8, "state held");
		n = 0;
		while (bus_on !== 1'b1 && n < 1000) begin
			@(posedge mclk);
			n++;
		end
		check("idle wait", n >= 160, 1'b1);
		rc(12'h208, 32'h10, "live");
		while (tick !== 1'b1) @(posedge mclk);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (tick !== 1'b1);
		check("bit clocks", n, 16);
		check("idle bit", sbit, 1'b1);
		// falling edge lands in phase one of the next bit: one quantum more
		n = 4;
		repeat (4) @(posedge mclk);
		dom <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (tick !== 1'b1);
		check("stretched bit", n, 18);
		check("sampled low", sbit, 1'b0);
		dom <= 1'b0;
		$display("test leave config done");
		eng_bit <= 1'b0;
		repeat (3) @(posedge mclk);
		check("tx follows", tx_pin, 1'b0);
		apb(1'b1, 12'h200, 32'h40);
		@(posedge mclk);
		check("tx held", tx_pin, 1'b1);
		eng_bit <= 1'b1;
		$display("test hold off done");
		busy <= 1'b1;
		tx_inc <= 1'b1;
		rx_inc <= 1'b1;
		repeat (2) @(posedge mclk);
		rx_inc <= 1'b0;
		@(posedge mclk);
		tx_inc <= 1'b0;
		rc(12'h214, 32'h0203, "err count");
		apb(1'b1, 12'h204, 32'h5);
		apb(1'b0, 12'h208, 32'h0);
		check("drain", rd[3], 1'b0);
		busy <= 1'b0;
		repeat (4) @(posedge mclk);
		rc(12'h208, 32'h8, "init done");
		rc(12'h214, 32'h0, "err cleared");
		rc(12'h210, 32'h2300, "bcr kept");
		$display("test soft reset done");
		standby <= 1'b1;
		repeat (3) @(posedge mclk);
		standby <= 1'b0;
		@(posedge mclk);
		rc(12'h20c, 32'h1, "flag again");
		rc(12'h204, 32'h1, "req again");
		rc(12'h210, 32'h0, "bcr reset");
		rc(12'h200, 32'h3, "mon reset");
		rc(12'h000, 32'h5a, "ram kept");
		$display("test standby done");
		tally_and_finish;
	end
endmodule : crm_can_ctrl_tb
